/* hw/jdis_consts.vh */
// Constants for the identification scan path of the test access port
`ifndef JDIS_CONSTS_VH
`define JDIS_CONSTS_VH

// ==========================================================
// Instruction register
`define JDIS_IR_WIDTH      4
`define JDIS_IR_IDCODE     4'h1
`define JDIS_IR_BYPASS     4'hF
`define JDIS_IR_CAPTURE    4'h1

// ==========================================================
// Identification register
`define JDIS_ID_WIDTH      32
`define JDIS_ID_VALUE      32'h1A5C303F
`define JDIS_ID_FILL       1'h1

// ==========================================================
// Controller state codes (one-hot, 16 states)
`define JDIS_ST_W          16
`define JDIS_TLR           16'h0001
`define JDIS_RTI           16'h0002
`define JDIS_SDRS          16'h0004
`define JDIS_CDR           16'h0008
`define JDIS_SHDR          16'h0010
`define JDIS_E1DR          16'h0020
`define JDIS_PDR           16'h0040
`define JDIS_E2DR          16'h0080
`define JDIS_UDR           16'h0100
`define JDIS_SIRS          16'h0200
`define JDIS_CIR           16'h0400
`define JDIS_SHIR          16'h0800
`define JDIS_E1IR          16'h1000
`define JDIS_PIR           16'h2000
`define JDIS_E2IR          16'h4000
`define JDIS_UIR           16'h8000

`endif

/* hw/jdis_sync.v */
// Two-stage synchroniser for the tester pins
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Synchroniser
module jdis_sync (
   input  wire        clock,
   input  wire        rstn,
   input  wire        din,
   output reg         dout
);
   reg                meta;

   // First stage feeds only the second stage
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // jdis_sync

`default_nettype wire

/* hw/jdis_top.v */
// Test access port with identification scan path and its constant-one fill
//
// Summary of operation
// (R1) Identification shift fills with one, not input
// (R2) Upstream bits lost; downstream sees all ones
// (R3) Test-Logic-Reset makes identification current instruction
// (R4) Bypass instruction routes through one-bit bypass
// (R5) Tester avoids downstream access during identification
// (R6) Board places this device first in chain
// (R7) Shifting never alters the stored identification
// (R8) 32-bit identification, captured, shifted LSB first
`timescale 1ns/1ps
`default_nettype none
`include "jdis_consts.vh"

module jdis_top (
   input  wire        CLOCK,
   input  wire        RSTN,
   input  wire        TCK,
   input  wire        TMS,
   input  wire        TDI,
   output reg         TDO,
   output reg         TDO_OE,
   output reg  [3:0]  IR_CURRENT,
   output reg         TAP_RESET
);
   localparam [`JDIS_ST_W-1:0] S_TLR  = `JDIS_TLR;
   localparam [`JDIS_ST_W-1:0] S_RTI  = `JDIS_RTI;
   localparam [`JDIS_ST_W-1:0] S_SDRS = `JDIS_SDRS;
   localparam [`JDIS_ST_W-1:0] S_CDR  = `JDIS_CDR;
   localparam [`JDIS_ST_W-1:0] S_SHDR = `JDIS_SHDR;
   localparam [`JDIS_ST_W-1:0] S_E1DR = `JDIS_E1DR;
   localparam [`JDIS_ST_W-1:0] S_PDR  = `JDIS_PDR;
   localparam [`JDIS_ST_W-1:0] S_E2DR = `JDIS_E2DR;
   localparam [`JDIS_ST_W-1:0] S_UDR  = `JDIS_UDR;
   localparam [`JDIS_ST_W-1:0] S_SIRS = `JDIS_SIRS;
   localparam [`JDIS_ST_W-1:0] S_CIR  = `JDIS_CIR;
   localparam [`JDIS_ST_W-1:0] S_SHIR = `JDIS_SHIR;
   localparam [`JDIS_ST_W-1:0] S_E1IR = `JDIS_E1IR;
   localparam [`JDIS_ST_W-1:0] S_PIR  = `JDIS_PIR;
   localparam [`JDIS_ST_W-1:0] S_E2IR = `JDIS_E2IR;
   localparam [`JDIS_ST_W-1:0] S_UIR  = `JDIS_UIR;

   wire                        tck_s;
   wire                        tms_s;
   wire                        tdi_s;
   reg                         tck_d;
   reg  [`JDIS_ST_W-1:0]       state;
   reg  [`JDIS_ST_W-1:0]       next_state;
   reg  [`JDIS_ID_WIDTH-1:0]   id_shift;
   reg                         bypass_bit;
   reg  [`JDIS_IR_WIDTH-1:0]   ir_shift;
   reg  [`JDIS_IR_WIDTH-1:0]   ir_hold;
   wire                        tck_rise;
   wire                        tck_fall;
   wire                        sel_id;

   // ==========================================================
   // Pin synchronisers
   jdis_sync u_sync_tck (
      .clock (CLOCK),
      .rstn  (RSTN),
      .din   (TCK),
      .dout  (tck_s)
   );
   jdis_sync u_sync_tms (
      .clock (CLOCK),
      .rstn  (RSTN),
      .din   (TMS),
      .dout  (tms_s)
   );
   jdis_sync u_sync_tdi (
      .clock (CLOCK),
      .rstn  (RSTN),
      .din   (TDI),
      .dout  (tdi_s)
   );

   // Edge detect on the synchronised test clock only
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end
   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;

   // Identification only for its own code; unknown codes fall to bypass
   assign sel_id = (ir_hold == `JDIS_IR_IDCODE);

   // ==========================================================
   // Controller next state
   always @* begin
      case (state)
         S_TLR:   next_state = tms_s ? S_TLR  : S_RTI;
         S_RTI:   next_state = tms_s ? S_SDRS : S_RTI;
         S_SDRS:  next_state = tms_s ? S_SIRS : S_CDR;
         S_CDR:   next_state = tms_s ? S_E1DR : S_SHDR;
         S_SHDR:  next_state = tms_s ? S_E1DR : S_SHDR;
         S_E1DR:  next_state = tms_s ? S_UDR  : S_PDR;
         S_PDR:   next_state = tms_s ? S_E2DR : S_PDR;
         S_E2DR:  next_state = tms_s ? S_UDR  : S_SHDR;
         S_UDR:   next_state = tms_s ? S_SDRS : S_RTI;
         S_SIRS:  next_state = tms_s ? S_TLR  : S_CIR;
         S_CIR:   next_state = tms_s ? S_E1IR : S_SHIR;
         S_SHIR:  next_state = tms_s ? S_E1IR : S_SHIR;
         S_E1IR:  next_state = tms_s ? S_UIR  : S_PIR;
         S_PIR:   next_state = tms_s ? S_E2IR : S_PIR;
         S_E2IR:  next_state = tms_s ? S_UIR  : S_SHIR;
         S_UIR:   next_state = tms_s ? S_SDRS : S_RTI;
         default: next_state = S_TLR;
      endcase
   end

   // ==========================================================
   // Controller, shift paths and instruction on test clock rise
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state      <= S_TLR;
         id_shift   <= `JDIS_ID_VALUE;
         bypass_bit <= 1'b0;
         ir_shift   <= `JDIS_IR_CAPTURE;
         ir_hold    <= `JDIS_IR_IDCODE;
      end else if (tck_rise) begin
         state <= next_state;
         case (state)
            S_TLR: begin
               ir_hold <= `JDIS_IR_IDCODE;              // see (R3)
            end
            S_CDR: begin
               if (sel_id) begin
                  id_shift <= `JDIS_ID_VALUE;           // see (R7) (R8)
               end else begin
                  bypass_bit <= 1'b0;
               end
            end
            S_SHDR: begin
               if (sel_id) begin
                  // Fill with one drops upstream data; see (R1) (R2)
                  id_shift <= {`JDIS_ID_FILL,
                               id_shift[`JDIS_ID_WIDTH-1:1]};
               end else begin
                  bypass_bit <= tdi_s;                  // see (R4)
               end
            end
            S_CIR: begin
               ir_shift <= `JDIS_IR_CAPTURE;
            end
            S_SHIR: begin
               ir_shift <= {tdi_s, ir_shift[`JDIS_IR_WIDTH-1:1]};
            end
            S_UIR: begin
               ir_hold <= ir_shift;                     // see (R4)
            end
            default: begin
               ir_hold <= ir_hold;
            end
         endcase
         // Entry into reset restores identification at once; see (R3)
         if (next_state == S_TLR) begin
            ir_hold <= `JDIS_IR_IDCODE;
         end
      end
   end
   // Stored value is the constant, so capture never sees shifted bits

   // ==========================================================
   // Output drive on test clock fall, as the standard requires
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         TDO    <= 1'b0;
         TDO_OE <= 1'b0;
      end else if (tck_fall) begin
         if (state == S_SHDR) begin
            TDO    <= sel_id ? id_shift[0] : bypass_bit; // see (R8)
            TDO_OE <= 1'b1;
         end else if (state == S_SHIR) begin
            TDO    <= ir_shift[0];
            TDO_OE <= 1'b1;
         end else begin
            TDO    <= 1'b0;
            TDO_OE <= 1'b0;
         end
      end
   end

   // Status outputs registered from the controller
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         IR_CURRENT <= `JDIS_IR_IDCODE;
         TAP_RESET  <= 1'b1;
      end else begin
         IR_CURRENT <= ir_hold;
         TAP_RESET  <= (state == S_TLR);
      end
   end
endmodule // jdis_top

`default_nettype wire

/* test/jdis_props.sv */
// Checker for the scan path pins
`timescale 1ns/1ps
`default_nettype none
`include "jdis_consts.vh"
// =====
// Checker
module jdis_props (
   input wire logic       CLOCK,
   input wire logic       RSTN,
   input wire logic       TCK,
   input wire logic       TDO,
   input wire logic       TDO_OE,
   input wire logic [3:0] IR_CURRENT,
   input wire logic       TAP_RESET
);
   logic [2:0] tck_s;
   logic [5:0] n_fall;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // Falls spent shifting the identification; saturates
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         tck_s <= 3'h0;
         n_fall <= 6'h00;
      end else begin
         tck_s <= {tck_s[1:0], TCK};
         if (!TDO_OE || IR_CURRENT != `JDIS_IR_IDCODE)
            n_fall <= 6'h00;
         else if (tck_s[2] && !tck_s[1] && n_fall != 6'h3F)
            n_fall <= n_fall + 6'h01;
      end
   end
   // Controller entering reset, then identification standing
   sequence s_tap_enter;
      $rose(TAP_RESET);
   endsequence
   sequence s_id_chosen;
      IR_CURRENT == `JDIS_IR_IDCODE;
   endsequence
   a_reset_selects_id: assert property (
      s_tap_enter |-> ##[0:3] s_id_chosen)
      else $error("id not selected at reset");
   a_reset_no_drive: assert property (
      TAP_RESET |-> !TDO_OE) else $error("output driven in reset");
   a_tdo_at_fall: assert property (
      $changed(TDO) |-> !$past(TCK, 2)) else $error("output moved early");
   a_oe_at_fall: assert property (
      $changed(TDO_OE) |-> !$past(TCK, 2)) else $error("enable moved early");
   a_ir_not_shifting: assert property (
      $changed(IR_CURRENT) |-> !TDO_OE) else $error("ir moved in shift");
   // Count equals the bit index shown; the exit fall drops the enable
   a_fill_ones: assert property (
      TDO_OE && n_fall >= 6'h20 |-> TDO) else $error("fill bit not one");
endmodule // jdis_props
bind jdis_top jdis_props i_props (.CLOCK(CLOCK), .RSTN(RSTN), .TCK(TCK),
   .TDO(TDO), .TDO_OE(TDO_OE), .IR_CURRENT(IR_CURRENT),
   .TAP_RESET(TAP_RESET));
`default_nettype wire

/* test/jdis_tester.sv */
// Tester model driving test clock, mode select and serial input
`timescale 1ns/1ps
`default_nettype none
// =====
// Tester
module jdis_tester (
   input  wire logic clock,
   input  wire logic tdo,
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi
);
   // Test clock rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One period: low four cycles, high four; lone device, so no
   // downstream data is ever sent under identification
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (4) @(posedge clock);
      #1;
      q = tdo;
      tck = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      tck = 1'b0;
   endtask
endmodule // jdis_tester
`default_nettype wire

/* test/jtag_device_id_scan_path_tb.sv */
// Testbench for the identification scan path
`timescale 1ns/1ps
`default_nettype none
`include "jdis_consts.vh"
// =====
// Bench
module jtag_device_id_scan_path_tb;
   logic       clock = 1'b0;
   logic       rstn = 1'b0;
   logic       q;
   int         fails = 0;
   int         checks_done = 0;
   int         cycles = 0;
   wire        tck, tms, tdi, tdo, tdo_oe, tap_reset;
   wire  [3:0] ir;
   // Clock
   always #50 clock = ~clock;
   jdis_top i_dut (.CLOCK(clock), .RSTN(rstn), .TCK(tck), .TMS(tms),
      .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .IR_CURRENT(ir),
      .TAP_RESET(tap_reset));
   jdis_tester i_tester (.clock(clock), .tdo(tdo), .tck(tck),
      .tms(tms), .tdi(tdi));
   task automatic chk(input string n, input logic [3:0] e,
                      input logic [3:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Walk mode select bits, LSB first
   task automatic go(input logic [7:0] ms, input int n);
      for (int i = 0; i < n; i++) i_tester.step(ms[i], 1'b0, q);
   endtask
   // Two identification scans, serial input held low
   task automatic t_idcode();
      logic [63:0] e;
      e = {32'hFFFFFFFF, `JDIS_ID_VALUE};
      chk("tap_reset", 4'h1, {3'h0, tap_reset});
      chk("ir_reset", `JDIS_IR_IDCODE, ir);
      repeat (2) begin
         go(8'h02, 4);
         for (int i = 0; i < 64; i++) begin
            i_tester.step(i == 63, 1'b0, q);
            chk("id_bit", {3'h0, e[i]}, {3'h0, q});
            chk("oe_shift", 4'h1, {3'h0, tdo_oe});
         end
         go(8'h01, 2);
         chk("oe_idle", 4'h0, {3'h0, tdo_oe});
      end
   endtask
   // Bypass load, one-bit path, then back to reset
   task automatic t_bypass();
      logic [9:0] e;
      e = {9'h0B5, 1'b0};
      go(8'h03, 4);
      for (int i = 0; i < 4; i++) begin
         i_tester.step(i == 3, 1'b1, q);
         chk("ir_capture", {3'h0, i == 0}, {3'h0, q});
      end
      go(8'h01, 2);
      repeat (6) @(posedge clock);
      #1;
      chk("ir_bypass", `JDIS_IR_BYPASS, ir);
      go(8'h02, 4);
      for (int i = 0; i < 9; i++) begin
         i_tester.step(i == 8, e[i+1], q);
         chk("bypass_bit", {3'h0, e[i]}, {3'h0, q});
      end
      // Five rises with mode select high end in reset and stay there
      go(8'h1F, 5);
      repeat (6) @(posedge clock);
      #1;
      chk("tlr_state", 4'h1, {3'h0, tap_reset});
      chk("tlr_ir", `JDIS_IR_IDCODE, ir);
   endtask
   // Ceiling on the run, well above the expected length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         finish_test();
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      #1;
      rstn = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      t_idcode();
      t_bypass();
      finish_test();
   end
endmodule // jtag_device_id_scan_path_tb
`default_nettype wire
